/* cdl_device.sv */
`default_nettype none
module cdl_device
  import cdl_pkg::*;
#(
  parameter int STATIC_COUNT = STATIC_SAMPLES,
  parameter int DATA_W       = SAMPLE_W
) (
  cdl_if.dev            lnk,          // Serial audio link
  input  wire logic     rst,          // Synchronous reset, link domain
  input  wire logic [DATA_W-1:0] adc_left,  // ADC sample, left
  input  wire logic [DATA_W-1:0] adc_right, // ADC sample, right
  output logic [DATA_W-1:0] dac_left,  // DAC sample, left
  output logic [DATA_W-1:0] dac_right, // DAC sample, right
  output logic [1:0]    dac_gain,     // Ramp level nonzero per channel, 0 = silent
  output logic [2:0]    dac_fmt_used, // Format the DAC path obeys
  output logic          clock_ratio_high // Ratio selection seen by clocking
);
  localparam int CNT_W = $clog2(STATIC_COUNT + 1);
  localparam int STEP_W = $clog2(RAMP_STEPS + 1);

  logic [7:0] dac_format_setup;
  logic [7:0] dac_control;
  logic [7:0] volume_mix;
  logic [7:0] adc_path_control;
  logic [7:0] mode_control_second;
  logic       fc_q;
  logic [5:0] bit_cnt;
  logic [DATA_W-1:0] rx_shift;
  logic [DATA_W-1:0] tx_shift;
  logic       frame_edge;
  logic       loop_on;
  logic       dither_on;
  logic       lfsr_bit;
  logic [15:0] lfsr;
  logic [1:0] static_hit;
  logic [1:0] muted;
  logic [STEP_W-1:0] ramp [2];
  logic [DATA_W-1:0] dac_in [2];

  assign frame_edge = lnk.frame_clock != fc_q;
  assign loop_on    = mode_control_second[LOOP_BIT];
  assign dither_on  = adc_path_control[SIXTEEN_BIT_DITHER_ENABLE_BIT];
  assign lfsr_bit   = lfsr[0];

  // ---------------------------------------------------------------
  // Control registers, written from the link domain
  // ---------------------------------------------------------------
  always_ff @(posedge lnk.link_clk) begin
    if (rst) begin
      dac_format_setup    <= RST_DAC_FORMAT_SETUP;
      dac_control         <= RST_DAC_CONTROL;
      volume_mix          <= RST_VOLUME_MIX;
      adc_path_control    <= RST_ADC_PATH;
      mode_control_second <= RST_MODE_SECOND;
    end else if (lnk.cfg_wr) begin
      unique case (lnk.cfg_addr)
        REG_DAC_FORMAT_SETUP:    dac_format_setup    <= lnk.cfg_wdata;
        REG_DAC_CONTROL:         dac_control         <= lnk.cfg_wdata;
        REG_VOLUME_MIX:          volume_mix          <= lnk.cfg_wdata;
        REG_ADC_PATH_CONTROL:    adc_path_control    <= lnk.cfg_wdata;
        REG_MODE_CONTROL_SECOND: mode_control_second <= lnk.cfg_wdata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Clock ratio and DAC format as seen by the data path
  // ---------------------------------------------------------------
  always_ff @(posedge lnk.link_clk) begin
    if (rst) begin
      clock_ratio_high <= 1'b0;
      dac_fmt_used     <= 3'h0;
    end else begin
      // Only the high bit selects among 256/384 and 768/1024
      clock_ratio_high <= dac_format_setup[RATIO_HIGH_BIT];
      if (!loop_on) begin
        dac_fmt_used <= dac_format_setup[DAC_FMT_LSB +: 3];
      end
    end
  end

  // ---------------------------------------------------------------
  // Bit counter and frame tracking
  // ---------------------------------------------------------------
  always_ff @(posedge lnk.link_clk) begin
    if (rst) begin
      fc_q    <= 1'b0;
      bit_cnt <= 6'h00;
    end else begin
      fc_q    <= lnk.frame_clock;
      bit_cnt <= frame_edge ? 6'h01 : bit_cnt + 6'h01;
    end
  end

  // Dither source
  always_ff @(posedge lnk.link_clk) begin
    if (rst) begin
      lfsr <= 16'hACE1;
    end else if (frame_edge) begin
      lfsr <= {lfsr[0] ^ lfsr[2] ^ lfsr[3] ^ lfsr[5], lfsr[15:1]};
    end
  end

  // Output word, ADC format; with dither, random 0 or 1 LSB added at bit 16 position
  function automatic logic [DATA_W-1:0] fmt_out(input logic [DATA_W-1:0] s,
                                                input logic d, input logic en);
    logic [DATA_W-1:0] w;
    w = s;
    if (en) begin
      w = {s[DATA_W-1 -: 16] + {15'h0000, d}, {(DATA_W-16){1'b0}}};
    end
    return w;
  endfunction : fmt_out

  // ---------------------------------------------------------------
  // Serial transmit: shift out MSB first, ADC format delay bit
  // ---------------------------------------------------------------
  always_ff @(posedge lnk.link_clk) begin
    if (rst) begin
      tx_shift <= '0;
      lnk.serial_audio_out <= 1'b0;
    end else begin
      if (frame_edge) begin
        tx_shift <= fmt_out(lnk.frame_clock ? adc_left : adc_right, lfsr_bit, dither_on);
      end else if ((bit_cnt != 6'h01) || !adc_path_control[ADC_FMT_BIT]) begin
        // Delayed format holds the MSB for one extra bit cycle
        tx_shift <= {tx_shift[DATA_W-2:0], 1'b0};
      end
      lnk.serial_audio_out <= tx_shift[DATA_W-1];
    end
  end
  // ---------------------------------------------------------------
  // Serial receive and loopback selection
  // ---------------------------------------------------------------
  always_ff @(posedge lnk.link_clk) begin
    if (rst) begin
      rx_shift  <= '0;
      dac_in[0] <= '0;
      dac_in[1] <= '0;
    end else begin
      rx_shift <= {rx_shift[DATA_W-2:0], lnk.serial_audio_in};
      // Word is complete once its 24 bits have been shifted in
      if (loop_on) begin
        if (frame_edge) begin
          dac_in[0] <= adc_left;
          dac_in[1] <= adc_right;
        end
      end else if (bit_cnt == 6'h18) begin
        if (lnk.frame_clock) begin
          dac_in[0] <= rx_shift;
        end else begin
          dac_in[1] <= rx_shift;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Static detection, ramping and mute control per channel
  // ---------------------------------------------------------------
  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      logic [CNT_W-1:0]  run;
      logic [STEP_W-1:0] lvl;
      logic              pin_n;
      logic              gain_q;
      logic              is_static;
      assign is_static  = (dac_in[c] == '0) || (dac_in[c] == '1);
      assign static_hit[c] = run == CNT_W'(STATIC_COUNT);
      assign ramp[c]       = lvl;
      assign lnk.mute_control_out_n[c] = pin_n;
      assign dac_gain[c]   = gain_q;
      // Count consecutive static samples
      always_ff @(posedge lnk.link_clk) begin
        if (rst) begin
          run <= '0;
        end else if (frame_edge && lnk.frame_clock == 1'(c)) begin
          if (!is_static) begin
            run <= '0;
          end else if (!static_hit[c]) begin
            run <= run + CNT_W'(1);
          end
        end
      end
      // Ramp gain toward target, zero-cross gated
      always_ff @(posedge lnk.link_clk) begin
        if (rst) begin
          lvl <= STEP_W'(RAMP_STEPS);
        end else if (frame_edge && (!volume_mix[ZERO_CROSS_BIT] || is_static
                     || dac_in[c][DATA_W-1] != dac_left[DATA_W-1])) begin
          if (muted[c] && ramp[c] != '0) begin
            lvl <= volume_mix[SOFT_RAMP_BIT] ? lvl - STEP_W'(1) : '0;
          end else if (!muted[c] && ramp[c] != STEP_W'(RAMP_STEPS)) begin
            lvl <= volume_mix[SOFT_RAMP_BIT] ? lvl + STEP_W'(1)
                                             : STEP_W'(RAMP_STEPS);
          end
        end
      end
      always_ff @(posedge lnk.link_clk) begin
        if (rst) begin
          pin_n  <= 1'b0;
          gain_q <= 1'b0;
        end else begin
          pin_n  <= !muted[c];
          gain_q <= lvl != '0;
        end
      end
    end
  endgenerate

  // Mute decision, joint when channels linked
  always_ff @(posedge lnk.link_clk) begin
    if (rst) begin
      muted <= 2'h0;
    end else if (!dac_control[AUTO_SIL_BIT]) begin
      muted <= 2'h0;
    end else if (dac_control[LINK_MUTE_BIT]) begin
      muted <= {2{&static_hit}};
    end else begin
      muted <= static_hit;
    end
  end

  // DAC outputs; held at midscale zero while the channel's ramp level is zero
  always_ff @(posedge lnk.link_clk) begin
    if (rst) begin
      dac_left  <= '0;
      dac_right <= '0;
    end else begin
      dac_left  <= (ramp[0] != '0) ? dac_in[0] : '0;
      dac_right <= (ramp[1] != '0) ? dac_in[1] : '0;
    end
  end
endmodule : cdl_device
`default_nettype wire

/* cdl_pkg.sv */
`default_nettype none
package cdl_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_DAC_FORMAT_SETUP    = 8'h01;
  localparam logic [7:0] REG_DAC_CONTROL         = 8'h02;
  localparam logic [7:0] REG_VOLUME_MIX          = 8'h03;
  localparam logic [7:0] REG_ADC_PATH_CONTROL    = 8'h06;
  localparam logic [7:0] REG_MODE_CONTROL_SECOND = 8'h07;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int DAC_FMT_LSB      = 0;   // dac_format_select [2:0]
  localparam int RATIO_LOW_BIT    = 3;   // clock_ratio_low in 01h
  localparam int RATIO_HIGH_BIT   = 4;   // clock_ratio_high in 01h
  localparam int AUTO_SIL_BIT     = 7;   // auto_silence_enable in 02h
  localparam int LINK_MUTE_BIT    = 6;   // mute_channels_linked in 02h
  localparam int SOFT_RAMP_BIT    = 1;   // soft ramp in 03h
  localparam int ZERO_CROSS_BIT   = 0;   // zero_cross_enable in 03h
  localparam int ADC_FMT_BIT      = 4;   // adc_format_select in 06h
  localparam int SIXTEEN_BIT_DITHER_ENABLE_BIT     = 5;   // sixteen_bit_dither_enable in 06h
  localparam int LOOP_BIT         = 4;   // loopback in 07h
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_DAC_FORMAT_SETUP = 8'h00;
  localparam logic [7:0] RST_DAC_CONTROL      = 8'h80;
  localparam logic [7:0] RST_VOLUME_MIX       = 8'h00;
  localparam logic [7:0] RST_ADC_PATH         = 8'h00;
  localparam logic [7:0] RST_MODE_SECOND      = 8'h00;
  // ---------------------------------------------------------------
  // Timing and sizes
  // ---------------------------------------------------------------
  localparam int STATIC_SAMPLES   = 8192;
  localparam int SAMPLE_W         = 24;
  localparam int BITS_PER_HALF    = 32;
  localparam int RAMP_STEPS       = 8;
  localparam logic [7:0] LINK_DIV = 8'h01;  // host link clock half period minus one, in core clocks
endpackage : cdl_pkg
`default_nettype wire

/* cdl_if.sv */
`default_nettype none
interface cdl_if;
  logic       link_clk;        // Bit clock from host
  logic       frame_clock;     // Frame clock, high = left
  logic       serial_audio_in; // Host to device data
  logic       serial_audio_out;// Device to host data
  logic       cfg_wr;          // Register write strobe (link clock)
  logic [7:0] cfg_addr;        // Register offset
  logic [7:0] cfg_wdata;       // Register write data
  logic [1:0] mute_control_out_n; // Active-low mute per channel
  modport dev (input link_clk, frame_clock, serial_audio_in, cfg_wr, cfg_addr, cfg_wdata,
               output serial_audio_out, mute_control_out_n);
  modport host (output link_clk, frame_clock, serial_audio_in, cfg_wr, cfg_addr, cfg_wdata,
                input serial_audio_out, mute_control_out_n);
endinterface : cdl_if
`default_nettype wire

/* cdl_host.sv */
`default_nettype none
module cdl_host
  import cdl_pkg::*;
#(
  parameter int DATA_W = SAMPLE_W
) (
  cdl_if.host           lnk,        // Serial audio link
  input  wire logic     core_clk,   // Host clock, 10 MHz
  input  wire logic     rst,        // Synchronous reset
  input  wire logic     cfg_req,    // Register write request, level toggled per write
  input  wire logic [7:0] cfg_addr, // Register offset
  input  wire logic [7:0] cfg_data, // Register data
  input  wire logic [DATA_W-1:0] play_left,  // Sample to send, left
  input  wire logic [DATA_W-1:0] play_right, // Sample to send, right
  output logic [15:0]   rec_word,   // Top sixteen bits received
  output logic [1:0]    muted       // Synchronised device mute state
);
  logic [7:0] div_cnt;
  logic       lclk;
  logic [5:0] bit_cnt;
  logic       fc;
  logic [DATA_W-1:0] tx_shift;
  logic [DATA_W-1:0] rx_shift;
  logic [1:0] m_s1;
  logic [1:0] m_s2;
  logic [1:0] m_s3;
  logic       req_q;
  logic       pend;
  logic [7:0] addr_q;
  logic [7:0] data_q;
  logic       wr_q;
  logic [7:0] wa_q;
  logic [7:0] wd_q;

  // ---------------------------------------------------------------
  // Link clock divider and frame generation, 64 bits per frame
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt <= 8'h00;
      lclk    <= 1'b0;
      bit_cnt <= 6'h00;
      fc      <= 1'b0;
      tx_shift <= '0;
      rx_shift <= '0;
      rec_word <= 16'h0000;
    end else if (div_cnt == LINK_DIV) begin
      div_cnt <= 8'h00;
      lclk    <= !lclk;
      if (lclk) begin
        bit_cnt  <= bit_cnt + 6'h01;
        fc       <= (bit_cnt[5] == (bit_cnt[4:0] == 5'h1F)); // Changes with the MSB
        tx_shift <= (bit_cnt[4:0] == 5'h1F) ? (bit_cnt[5] ? play_left : play_right)
                                             : {tx_shift[DATA_W-2:0], 1'b0};
      end else begin
        rx_shift <= {rx_shift[DATA_W-2:0], lnk.serial_audio_out};
        // All 24 bits of the half are in by bit 26
        if (bit_cnt[4:0] == 5'h1A) begin
          rec_word <= rx_shift[DATA_W-1 -: 16];
        end
      end
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  assign lnk.link_clk        = lclk;
  assign lnk.frame_clock     = fc;
  assign lnk.serial_audio_in = tx_shift[DATA_W-1];
  // Request toggle captured, then issued as one link cycle pulse from a falling edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_q  <= 1'b0;
      pend   <= 1'b0;
      addr_q <= 8'h00;
      data_q <= 8'h00;
    end else begin
      req_q <= cfg_req;
      if (cfg_req != req_q) begin
        pend   <= 1'b1;
        addr_q <= cfg_addr;
        data_q <= cfg_data;
      end else if (div_cnt == LINK_DIV && lclk) begin
        pend <= 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      wd_q <= 8'h00;
    end else if (div_cnt == LINK_DIV && lclk) begin
      wr_q <= pend && (cfg_req == req_q);
      wa_q <= addr_q;
      wd_q <= data_q;
    end
  end

  assign lnk.cfg_wr          = wr_q;
  assign lnk.cfg_addr        = wa_q;
  assign lnk.cfg_wdata       = wd_q;

  // Mute pins synchronised, three stages
  always_ff @(posedge core_clk) begin
    if (rst) begin
      m_s1  <= 2'h3;
      m_s2  <= 2'h3;
      m_s3  <= 2'h3;
      muted <= 2'h0;
    end else begin
      m_s1 <= lnk.mute_control_out_n;
      m_s2 <= m_s1;
      m_s3 <= m_s2;
      if (m_s2 == m_s3) begin
        muted <= ~m_s3;
      end
    end
  end
endmodule : cdl_host
`default_nettype wire

/* cdl_monitor.sv */
`default_nettype none
module cdl_monitor
  import cdl_pkg::*;
#(
  parameter int STATIC_COUNT = STATIC_SAMPLES
) (
  input  wire logic       link_clk,           // Bit clock
  input  wire logic       rst,                // Synchronous reset
  input  wire logic       frame_clock,        // Frame clock
  input  wire logic       cfg_wr,             // Register write strobe
  input  wire logic [7:0] cfg_addr,           // Register offset
  input  wire logic [7:0] cfg_wdata,          // Register data
  input  wire logic [1:0] mute_control_out_n  // Active-low mute pins
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge link_clk); endclocking
  default disable iff (rst);

  logic [7:0]  bit_cnt;   // Bit cycles since last frame edge
  logic        fc_q;      // Frame clock one cycle ago
  logic        seen;      // A frame edge has been seen
  logic        auto_on;   // Shadow of auto silence bit
  logic        link_on;   // Shadow of linked mute bit
  logic [7:0]  link_age;  // Cycles since linking was switched on
  logic [15:0] frames;    // Frames since reset

  // ---------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------
  // Half-frame length counter
  always_ff @(posedge link_clk) begin
    fc_q    <= frame_clock;
    bit_cnt <= (rst || frame_clock != fc_q) ? 8'h00 : bit_cnt + 8'h01;
    seen    <= !rst && (seen || frame_clock != fc_q);
    frames  <= rst ? 16'h0000 : frames + 16'((frame_clock && !fc_q && frames != 16'hFFFF));
  end
  // Shadow of the mute control register
  always_ff @(posedge link_clk) begin
    if (rst) begin
      auto_on <= 1'b1;
      link_on <= 1'b0;
    end else if (cfg_wr && cfg_addr == REG_DAC_CONTROL) begin
      auto_on <= cfg_wdata[AUTO_SIL_BIT];
      link_on <= cfg_wdata[LINK_MUTE_BIT];
    end
  end
  // Time spent with linking switched on
  always_ff @(posedge link_clk) begin
    link_age <= (rst || !link_on) ? 8'h00 : link_age + 8'((link_age != 8'hFF));
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_reset_muted: assert property ($fell(rst) |-> mute_control_out_n == 2'h0)
    else $error("mute pins not active right after reset");
  a_cfg_single: assert property (cfg_wr |=> !cfg_wr)
    else $error("register strobe longer than one bit cycle");
  a_half_len: assert property (seen && frame_clock != fc_q |-> bit_cnt == 8'(BITS_PER_HALF - 1))
    else $error("half frame not 32 bit cycles");
  a_half_max: assert property (seen |-> bit_cnt < 8'(BITS_PER_HALF))
    else $error("frame clock stuck");
  a_linked_pair: assert property (link_age == 8'hFF |-> mute_control_out_n[0] == mute_control_out_n[1])
    else $error("linked channels muted differently");
  a_auto_off_hold: assert property (!auto_on |=> !$fell(mute_control_out_n[0]) && !$fell(mute_control_out_n[1]))
    else $error("mute entered with auto silence off");
  a_mute_left_count: assert property ($fell(mute_control_out_n[0]) |-> frames >= 16'(STATIC_COUNT - 1))
    else $error("left muted before static run complete");
  a_mute_right_count: assert property ($fell(mute_control_out_n[1]) |-> frames >= 16'(STATIC_COUNT - 1))
    else $error("right muted before static run complete");
endmodule : cdl_monitor
`default_nettype wire

/* codec_loopback_dither_automute_test.sv */
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module codec_loopback_dither_automute_test;
  import cdl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 8;  // Shortened static run

  logic        core_clk = 1'b0;    // Host clock
  logic        rst = 1'b1;         // Host reset
  logic        dev_rst = 1'b1;     // Device reset, link domain
  logic        cfg_req = 1'b0;     // Write strobe request
  logic [7:0]  cfg_addr = 8'h00;   // Write offset
  logic [7:0]  cfg_data = 8'h00;   // Write data
  logic [23:0] play_left = 24'h0, play_right = 24'hFFFFFF, adc_left = 24'h0, adc_right = 24'h0;
  logic [23:0] dac_left, dac_right;
  logic [15:0] rec_word;
  logic [1:0]  muted, dac_gain;
  logic [2:0]  dac_fmt_used;
  logic        clock_ratio_high;
  int          error_cnt = 0, cmp_count = 0;

  cdl_if cdl_if_i ();
  cdl_host cdl_host_i (.lnk(cdl_if_i), .core_clk(core_clk), .rst(rst), .cfg_req(cfg_req),
    .cfg_addr(cfg_addr), .cfg_data(cfg_data), .play_left(play_left), .play_right(play_right),
    .rec_word(rec_word), .muted(muted));
  cdl_device #(.STATIC_COUNT(SC)) cdl_device_i (.lnk(cdl_if_i), .rst(dev_rst), .adc_left(adc_left),
    .adc_right(adc_right), .dac_left(dac_left), .dac_right(dac_right), .dac_gain(dac_gain),
    .dac_fmt_used(dac_fmt_used), .clock_ratio_high(clock_ratio_high));
  cdl_monitor #(.STATIC_COUNT(SC)) cdl_monitor_i (.link_clk(cdl_if_i.link_clk), .rst(dev_rst),
    .frame_clock(cdl_if_i.frame_clock), .cfg_wr(cdl_if_i.cfg_wr), .cfg_addr(cdl_if_i.cfg_addr),
    .cfg_wdata(cdl_if_i.cfg_wdata), .mute_control_out_n(cdl_if_i.mute_control_out_n));

  // ---------------------------------------------------------------
  // Clock, helpers and closing
  // ---------------------------------------------------------------
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // One register write: toggle the request, then wait until it has landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cfg_addr <= a;
    cfg_data <= d;
    cfg_req  <= !cfg_req;
    repeat (20) @(posedge core_clk);
  endtask : wr
  task automatic frames(input int n);
    repeat (n) @(posedge cdl_if_i.frame_clock);
  endtask : frames
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Ratio high bit after reset and for all four codes
  task automatic t_ratio;
    `CHK(clock_ratio_high, 1'b0)
    for (int i = 0; i < 4; i++) begin
      wr(REG_DAC_FORMAT_SETUP, 8'(i << RATIO_LOW_BIT));
      `CHK(clock_ratio_high, i[1])
    end
    $display("test ratio done");
  endtask : t_ratio
  // Static zero and minus-one runs, release, linking, disable
  task automatic t_automute;
    frames(SC + 4);
    `CHK(muted, 2'b11)
    `CHK(cdl_if_i.mute_control_out_n, 2'b00)
    play_left <= 24'h000100;
    frames(3);
    `CHK(muted, 2'b10)
    wr(REG_DAC_CONTROL, 8'hC0);
    frames(3);
    `CHK(muted, 2'b00)
    play_left <= 24'h000000;
    frames(SC + 4);
    `CHK(muted, 2'b11)
    wr(REG_DAC_CONTROL, 8'h00);
    play_left <= 24'h000001;
    frames(3);
    play_left <= 24'h000000;
    frames(SC + 4);
    `CHK(muted, 2'b00)
    $display("test automute done");
  endtask : t_automute
  // Loopback, held DAC format, unmapped write
  task automatic t_loop;
    adc_left   <= 24'h123456;
    adc_right  <= 24'h123456;
    play_left  <= 24'hABCDEF;
    play_right <= 24'hABCDEF;
    wr(REG_DAC_FORMAT_SETUP, 8'h05);
    `CHK(dac_fmt_used, 3'h5)
    wr(REG_MODE_CONTROL_SECOND, 8'h10);
    wr(REG_DAC_FORMAT_SETUP, 8'h02);
    frames(4);
    `CHK(dac_left, 24'h123456)
    `CHK(rec_word, 16'h1234)
    `CHK(dac_fmt_used == 3'h2, 1'b0)
    wr(REG_MODE_CONTROL_SECOND, 8'h00);
    wr(8'h05, 8'hFF);
    `CHK(dac_fmt_used, 3'h2)
    frames(4);
    `CHK(dac_left, 24'hABCDEF)
    $display("test loop done");
  endtask : t_loop
  // Dither keeps the top sixteen bits within one step
  task automatic t_dither;
    adc_left  <= 24'h1234FF;
    adc_right <= 24'h1234FF;
    wr(REG_ADC_PATH_CONTROL, 8'h20);
    frames(4);
    `CHK(rec_word == 16'h1234 || rec_word == 16'h1235, 1'b1)
    wr(REG_ADC_PATH_CONTROL, 8'h00);
    frames(4);
    `CHK(rec_word, 16'h1234)
    $display("test dither done");
  endtask : t_dither

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(negedge cdl_if_i.link_clk);
    dev_rst <= 1'b0;
    repeat (2) @(posedge cdl_if_i.link_clk);
    t_ratio();
    t_automute();
    t_loop();
    t_dither();
    give_verdict();
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    error_cnt++;
    $display("unexpected at %0t: run did not finish", $time);
    give_verdict();
  end
endmodule : codec_loopback_dither_automute_test
`undef CHK
`default_nettype wire
